// *** acq_cfg_regs.sv ***
// acquisition configuration register bank with apb slave
// Notes on behaviour
// RULE_01 - bits 19:16 pick suppression: 0 none, 2 zero-length, 3 amplitude
// RULE_02 - bit 11 turns dense sample packing on for all channels
// RULE_03 - bit 6 set fires self-triggers under threshold, clear over
// RULE_04 - bit 4 clear random memory access, set sequential
// RULE_05 - bit 3 replaces samples with a test pattern
// RULE_06 - bit 1 allows overlapping trigger windows
// RULE_07 - shared config applies to all channels, resets to 0x10
// RULE_08 - set alias forces ones in writable bits where written low byte has ones
// RULE_09 - clear alias forces zeros where written low byte has ones
// RULE_10 - division code splits memory into two-to-the-code blocks, max 1024
// RULE_11 - each write of division register also clears acquisition logic
// RULE_12 - software must not write division or size while running
// RULE_13 - writing N to release register frees N oldest blocks
// RULE_14 - event size zero disables custom sizing, else locations per event
// RULE_15 - control bit 3 set counts all triggers, clear accepted only
// RULE_16 - setting run bit resets memory, then enters run (mode 01: at the next sync rising edge)
// RULE_17 - clearing run stops, keeps data; stopped ignores triggers
// RULE_18 - two-bit start mode selects one of four modes
// RULE_19 - mode 00: run bit only, gate open, sync from sync input
// RULE_20 - mode 01: sync input is sync and run start, gate open
// RULE_21 - mode 10: no board sync, sync input is the gate
// RULE_22 - mode 11: board synchronisation only
// RULE_23 - freeing more blocks than occupied raises buffer-free error
// RULE_24 - alias reads return zero; aliases never touch bits above 7
`timescale 1ns/10ps
`include "acq_cfg_params.svh"
module acq_cfg_regs (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [15:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    // acquisition side
    input  wire logic                 sync_in,
    input  wire logic                 trigger_in,
    input  wire logic                 event_stored,
    output acq_cfg_pkg::chan_cfg_t    chan_cfg,
    output acq_cfg_pkg::acq_ctl_t     acq_ctl,
    output logic [3:0]                block_div,
    output logic [31:0]               event_location_count,
    output logic                      custom_size_on,
    output logic                      memory_reset,
    output logic                      trigger_accept,
    output logic                      count_pulse
);
    logic [31:0]              cfg_q, cfg_d;
    logic [3:0]               blk_q, blk_d;
    logic [11:0]              rel_q, rel_d;
    logic [31:0]              evs_q, evs_d;
    logic [3:0]               acq_q, acq_d;
    acq_cfg_pkg::run_state_t  st_q, st_d;
    logic                     ready_q, ready_d;
    logic [31:0]              rdata_q, rdata_d;
    logic                     err_q, err_d;
    logic                     mrst_q, mrst_d;
    logic                     acc_q, acc_d;
    logic                     cnt_q, cnt_d;
    logic                     sync_q, sync_d;
    logic                     rel_req;
    logic                     soft_clr;
    logic [`OCC_W-1:0]        occupied;
    logic [`OCC_W-1:0]        blocks;
    logic                     free_err;
    logic                     access;
    logic                     wr;
    acq_cfg_pkg::start_mode_t mode;
    logic                     gate;
    acq_cfg_pkg::acq_ctl_t    ctl_q, ctl_d;
    logic                     csz_q, csz_d;

    // address decode shared by read and write paths
    function automatic logic mapped(input logic [15:0] a);
        case (a)
            `OFF_CFG, `OFF_CFG_SET, `OFF_CFG_CLR, `OFF_BLK_DIV,
            `OFF_REL, `OFF_EVSIZE, `OFF_ACQ, `OFF_STAT: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction

    assign access   = psel && penable && ready_q;
    assign wr       = access && pwrite && mapped(paddr);
    assign rel_req  = wr && paddr == `OFF_REL;
    assign soft_clr = wr && paddr == `OFF_BLK_DIV;  // [RULE_11]
    assign mode     = acq_cfg_pkg::start_mode_t'(acq_q[1:0]);  // [RULE_18]

    block_pool block_pool_i (
        .pclk          (pclk),
        .presetn       (presetn),
        .clear         (soft_clr || mrst_q),
        .div_code      (blk_q),
        .fill          (event_stored && st_q == acq_cfg_pkg::st_run),
        .release_req   (rel_req),
        .release_count (pwdata[11:0]),
        .occupied      (occupied),
        .free_error    (free_err),
        .block_count   (blocks)
    );

    // register writes
    always_comb begin
        cfg_d = cfg_q;
        blk_d = blk_q;
        rel_d = rel_q;
        evs_d = evs_q;
        acq_d = acq_q;
        if (wr) begin
            case (paddr)
                `OFF_CFG:     cfg_d = pwdata & `CFG_MASK;
                `OFF_CFG_SET: cfg_d = (cfg_q | (pwdata & `ALIAS_MASK))
                                      & `CFG_MASK;  // [RULE_08] [RULE_24]
                `OFF_CFG_CLR: cfg_d = cfg_q
                                      & ~(pwdata & `ALIAS_MASK);  // [RULE_09]
                `OFF_BLK_DIV: blk_d = pwdata[3:0];  // [RULE_10]
                `OFF_REL:     rel_d = pwdata[11:0];
                `OFF_EVSIZE:  evs_d = pwdata;  // [RULE_14]
                `OFF_ACQ:     acq_d = pwdata[3:0];
                default:      acq_d = acq_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_q <= `CFG_RESET;  // [RULE_07]
            blk_q <= '0;
            rel_q <= '0;
            evs_q <= '0;
            acq_q <= '0;
        end else begin
            cfg_q <= cfg_d;
            blk_q <= blk_d;
            rel_q <= rel_d;
            evs_q <= evs_d;
            acq_q <= acq_d;
        end
    end

    // apb answer: one wait state, then ready for one cycle
    always_comb begin
        ready_d = 1'b0;
        rdata_d = '0;
        err_d   = 1'b0;
        if (psel && penable && !ready_q) begin
            ready_d = 1'b1;
            err_d   = !mapped(paddr);
            if (!pwrite) begin
                case (paddr)
                    `OFF_CFG:     rdata_d = cfg_q;
                    `OFF_BLK_DIV: rdata_d = {28'h0, blk_q};
                    `OFF_REL:     rdata_d = {20'h0, rel_q};
                    `OFF_EVSIZE:  rdata_d = evs_q;
                    `OFF_ACQ:     rdata_d = {28'h0, acq_q};
                    `OFF_STAT:    rdata_d = {free_err, 4'h0, blocks,
                                             occupied, 2'h0,
                                             st_q == acq_cfg_pkg::st_run,
                                             2'h0};  // [RULE_23]
                    default:      rdata_d = '0;  // [RULE_24]
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_q <= 1'b0;
            rdata_q <= '0;
            err_q   <= 1'b0;
        end else begin
            ready_q <= ready_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    // run control and start modes
    always_comb begin
        st_d   = st_q;
        mrst_d = 1'b0;
        sync_d = sync_in;
        case (st_q)
            acq_cfg_pkg::st_stop: begin
                if (acq_q[`BIT_RUN]) begin
                    st_d = acq_cfg_pkg::st_clr;
                end
            end
            acq_cfg_pkg::st_clr: begin
                mrst_d = 1'b1;  // [RULE_16]
                if (mode == acq_cfg_pkg::sync_driven_start_mode) begin
                    st_d = acq_cfg_pkg::st_arm;
                end else begin
                    st_d = acq_cfg_pkg::st_run;
                end
            end
            acq_cfg_pkg::st_arm: begin
                if (!acq_q[`BIT_RUN]) begin
                    st_d = acq_cfg_pkg::st_stop;
                end else if (sync_in && !sync_q) begin
                    st_d = acq_cfg_pkg::st_run;  // [RULE_20]
                end
            end
            acq_cfg_pkg::st_run: begin
                if (!acq_q[`BIT_RUN]) begin
                    st_d = acq_cfg_pkg::st_stop;  // [RULE_17]
                end
            end
            default: st_d = acq_cfg_pkg::st_stop;
        endcase
    end

    // gate follows sync input only in gate mode
    assign gate = (mode == acq_cfg_pkg::sync_gate_mode) ? sync_in
                                                        : 1'b1;  // [RULE_19]

    always_comb begin
        acc_d = trigger_in && gate
                && st_q == acq_cfg_pkg::st_run;  // [RULE_17] [RULE_21]
        cnt_d = acq_q[`BIT_TALLY] ? (trigger_in
                && st_q == acq_cfg_pkg::st_run)
                : acc_d;  // [RULE_15]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= acq_cfg_pkg::st_stop;
            mrst_q <= 1'b0;
            acc_q  <= 1'b0;
            cnt_q  <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            mrst_q <= mrst_d;
            acc_q  <= acc_d;
            cnt_q  <= cnt_d;
            sync_q <= sync_d;
        end
    end

    // control flags decoded from next values, so they stay in step
    always_comb begin
        ctl_d.running     = st_d == acq_cfg_pkg::st_run;
        ctl_d.gate_open   = acc_d;
        ctl_d.sync_enable = acq_cfg_pkg::start_mode_t'(acq_d[1:0])
            != acq_cfg_pkg::sync_gate_mode;  // [RULE_21] [RULE_22]
        ctl_d.tally_all   = acq_d[`BIT_TALLY];
        ctl_d.zero_length_encoding =
            cfg_d[`ZS_LSB+3:`ZS_LSB] == `SUPP_ZERO_LEN;  // [RULE_01]
        ctl_d.amplitude_full_suppression =
            cfg_d[`ZS_LSB+3:`ZS_LSB] == `SUPP_AMPL;  // [RULE_01]
        csz_d = evs_d != '0;  // [RULE_14]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= `CTL_RESET;
            csz_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            csz_q <= csz_d;
        end
    end

    // outputs, all taken from flip-flops
    assign pready  = ready_q;
    assign prdata  = rdata_q;
    assign pslverr = err_q;
    assign chan_cfg.suppression =
        cfg_q[`ZS_LSB+3:`ZS_LSB];  // [RULE_01]
    assign chan_cfg.dense_sample_packing =
        cfg_q[`BIT_PACK];  // [RULE_02]
    assign chan_cfg.trigger_on_under  = cfg_q[`BIT_UNDER];  // [RULE_03]
    assign chan_cfg.sequential_access = cfg_q[`BIT_SEQ];    // [RULE_04]
    assign chan_cfg.test_pattern      = cfg_q[`BIT_TEST];   // [RULE_05]
    assign chan_cfg.overlap_allowed   = cfg_q[`BIT_OVL];    // [RULE_06]
    assign acq_ctl              = ctl_q;
    assign block_div            = blk_q;
    assign event_location_count = evs_q;
    assign custom_size_on       = csz_q;  // [RULE_14]
    assign memory_reset         = mrst_q;
    assign trigger_accept       = acc_q;
    assign count_pulse          = cnt_q;

    a_alias_set: assert property (  // [RULE_08]
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == `OFF_CFG_SET |=> cfg_q[31:8] == $past(cfg_q[31:8]))
        else $error("set alias touched high bits");
    a_alias_clr: assert property (  // [RULE_09]
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == `OFF_CFG_CLR && pwdata[`BIT_SEQ]
        |=> !cfg_q[`BIT_SEQ])
        else $error("clear alias failed");
    a_run_reset: assert property (  // [RULE_16]
        @(posedge pclk) disable iff (!presetn)
        st_q == acq_cfg_pkg::st_stop && acq_q[`BIT_RUN] |=> ##1 mrst_q)
        else $error("no memory reset at run");
    a_stop_ignore: assert property (  // [RULE_17]
        @(posedge pclk) disable iff (!presetn)
        st_q != acq_cfg_pkg::st_run |=> !acc_q)
        else $error("trigger accepted while stopped");
    a_gate_mode: assert property (  // [RULE_21]
        @(posedge pclk) disable iff (!presetn)
        mode == acq_cfg_pkg::sync_gate_mode && !sync_in |=> !acc_q)
        else $error("gate ignored");
    a_div_clear: assert property (  // [RULE_11]
        @(posedge pclk) disable iff (!presetn)
        soft_clr |=> occupied == '0)
        else $error("division write did not clear");
    a_free_err: assert property (  // [RULE_23]
        @(posedge pclk) disable iff (!presetn)
        rel_req && !soft_clr && !mrst_q
        && {1'b0, pwdata[11:0]} > 13'(occupied) |=> free_err)
        else $error("free error not raised");
    a_tally_all: assert property (  // [RULE_15]
        @(posedge pclk) disable iff (!presetn)
        acc_d |=> cnt_q)
        else $error("accepted trigger not counted");
    a_sync_flag: assert property (  // [RULE_21]
        @(posedge pclk) disable iff (!presetn)
        acq_ctl.sync_enable == (mode != acq_cfg_pkg::sync_gate_mode))
        else $error("sync enable does not follow mode");
    a_run_flag: assert property (  // [RULE_16]
        @(posedge pclk) disable iff (!presetn)
        acq_ctl.running == (st_q == acq_cfg_pkg::st_run))
        else $error("running flag out of step");
    a_size_flag: assert property (  // [RULE_14]
        @(posedge pclk) disable iff (!presetn)
        custom_size_on == (evs_q != '0))
        else $error("custom size flag wrong");
    a_cfg_reserved: assert property (  // [RULE_07]
        @(posedge pclk) disable iff (!presetn)
        (cfg_q & ~`CFG_MASK) == '0)
        else $error("reserved config bit set");
endmodule

// *** acq_cfg_params.svh ***
// constants for the acquisition configuration register bank
`ifndef ACQ_CFG_PARAMS_SVH
`define ACQ_CFG_PARAMS_SVH
`define OFF_CFG        16'h8000
`define OFF_CFG_SET    16'h8004
`define OFF_CFG_CLR    16'h8008
`define OFF_BLK_DIV    16'h800c
`define OFF_REL        16'h8010
`define OFF_EVSIZE     16'h8020
`define OFF_ACQ        16'h8100
`define OFF_STAT       16'h8104
`define CFG_RESET      32'h0000_0010
`define CFG_MASK       32'h000f_085a
`define ALIAS_MASK     32'h0000_00ff
`define BLK_MASK       32'h0000_000f
`define REL_MASK       32'h0000_0fff
`define ACQ_MASK       32'h0000_000f
`define ZS_LSB         16
`define SUPP_NONE      4'h0
`define SUPP_ZERO_LEN  4'h2
`define SUPP_AMPL      4'h3
`define CTL_RESET      6'h08
`define BIT_PACK       11
`define BIT_UNDER      6
`define BIT_SEQ        4
`define BIT_TEST       3
`define BIT_OVL        1
`define BIT_TALLY      3
`define BIT_RUN        2
`define BLK_MAX        4'ha
`define OCC_W          11
`endif

// *** acq_cfg_pkg.sv ***
// types for the acquisition configuration register bank
package acq_cfg_pkg;
    typedef enum logic [3:0] {
        st_stop = 4'b0001,
        st_arm  = 4'b0010,
        st_run  = 4'b0100,
        st_clr  = 4'b1000
    } run_state_t;
    typedef enum logic [1:0] {
        bit_driven_start_mode  = 2'h0,
        sync_driven_start_mode = 2'h1,
        sync_gate_mode         = 2'h2,
        multi_board_sync_mode  = 2'h3
    } start_mode_t;
    typedef struct packed {
        logic [3:0] suppression;
        logic       dense_sample_packing;
        logic       trigger_on_under;
        logic       sequential_access;
        logic       test_pattern;
        logic       overlap_allowed;
    } chan_cfg_t;
    typedef struct packed {
        logic       running;
        logic       gate_open;
        logic       sync_enable;
        logic       tally_all;
        logic       zero_length_encoding;
        logic       amplitude_full_suppression;
    } acq_ctl_t;
endpackage

// *** block_pool.sv ***
// occupancy tracker for the output memory blocks
`timescale 1ns/10ps
`include "acq_cfg_params.svh"
module block_pool (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // control
    input  wire logic              clear,
    input  wire logic [3:0]        div_code,
    input  wire logic              fill,
    input  wire logic              release_req,
    input  wire logic [11:0]       release_count,
    // status
    output logic [`OCC_W-1:0]      occupied,
    output logic                   free_error,
    output logic [`OCC_W-1:0]      block_count
);
    logic [`OCC_W-1:0] occ_q;
    logic [`OCC_W-1:0] occ_d;
    logic              err_q;
    logic              err_d;
    logic [`OCC_W-1:0] cnt;

    // two to the power of the code, capped at the largest code
    always_comb begin
        if (div_code > `BLK_MAX) begin
            cnt = `OCC_W'(1) << `BLK_MAX;
        end else begin
            cnt = `OCC_W'(1) << div_code;
        end
    end

    always_comb begin
        occ_d = occ_q;
        err_d = err_q;
        if (clear) begin
            // a free request in the clearing cycle still asks too much
            occ_d = '0;
            err_d = release_req && release_count != 12'h0;  // [RULE_23]
        end else if (release_req) begin
            // oldest blocks leave first; too many frees flags an error
            if ({1'b0, release_count} > 13'(occ_q)) begin  // [RULE_23]
                occ_d = '0;
                err_d = 1'b1;
            end else begin
                occ_d = occ_q - release_count[`OCC_W-1:0];  // [RULE_13]
            end
        end else if (fill && occ_q < cnt) begin
            occ_d = occ_q + `OCC_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            occ_q <= '0;
            err_q <= 1'b0;
        end else begin
            occ_q <= occ_d;
            err_q <= err_d;
        end
    end

    assign occupied    = occ_q;
    assign free_error  = err_q;
    assign block_count = cnt;
endmodule

// *** acq_cfg_regs_tb.sv ***
// self-checking bench for the acquisition configuration register bank
`timescale 1ns/10ps
`include "acq_cfg_params.svh"
module acq_cfg_regs_tb;
    logic                    pclk;
    logic                    presetn;
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [15:0]             paddr;
    logic [31:0]             pwdata;
    logic                    pready;
    logic [31:0]             prdata;
    logic                    pslverr;
    logic                    sync_in;
    logic                    trigger_in;
    logic                    event_stored;
    acq_cfg_pkg::chan_cfg_t  chan_cfg;
    acq_cfg_pkg::acq_ctl_t   acq_ctl;
    logic [3:0]              block_div;
    logic [31:0]             event_location_count;
    logic                    custom_size_on;
    logic                    memory_reset;
    logic                    trigger_accept;
    logic                    count_pulse;
    int                      err_total;
    int                      num_checks;
    int                      seed;
    int                      op;
    int                      n;
    logic [31:0]             rdat;
    logic                    rerr;
    logic [31:0]             cfg_m;
    logic [31:0]             v;
    logic                    seen;

    acq_cfg_regs acq_cfg_regs_i (
        .pclk                 (pclk),
        .presetn              (presetn),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .paddr                (paddr),
        .pwdata               (pwdata),
        .pready               (pready),
        .prdata               (prdata),
        .pslverr              (pslverr),
        .sync_in              (sync_in),
        .trigger_in           (trigger_in),
        .event_stored         (event_stored),
        .chan_cfg             (chan_cfg),
        .acq_ctl              (acq_ctl),
        .block_div            (block_div),
        .event_location_count (event_location_count),
        .custom_size_on       (custom_size_on),
        .memory_reset         (memory_reset),
        .trigger_accept       (trigger_accept),
        .count_pulse          (count_pulse)
    );

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) check(32'h0, 32'h1, "no pready");
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask

    task automatic wait_run();
        int k;
        k = 0;
        while (acq_ctl.running !== 1'b1 && k < 10) begin
            @(posedge pclk);
            k++;
        end
    endtask

    task automatic pulse_events(input int cnt);
        repeat (cnt) begin
            @(posedge pclk);
            event_stored <= 1'b1;
            @(posedge pclk);
            event_stored <= 1'b0;
        end
    endtask

    // expected config word after a plain, set or clear write
    function automatic logic [31:0] cfg_next(input int kind,
                                            input logic [31:0] cur,
                                            input logic [31:0] d);
        logic [31:0] m;
        m = d & `ALIAS_MASK & `CFG_MASK;
        case (kind)
            0: cfg_next = d & `CFG_MASK;
            1: cfg_next = cur | m;
            default: cfg_next = cur & ~m;
        endcase
    endfunction

    initial begin
        #160000;
        check(32'h0, 32'h1, "watchdog");
        test_done();
    end

    initial begin
        seed = 50;
        err_total = 0;
        num_checks = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0000;
        pwdata = 32'h0000_0000;
        sync_in = 1'b0;
        trigger_in = 1'b0;
        event_stored = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `OFF_CFG, 32'h0);
        check(rdat, `CFG_RESET, "cfg reset");
        check(chan_cfg.sequential_access, 1'b1, "seq reset");
        cfg_m = `CFG_RESET;
        for (int i = 0; i < 24; i++) begin
            v = $random(seed);
            op = (i < 3) ? 0 : {$random(seed)} % 3;
            if (i < 3) begin
                v[19:16] = (i == 0) ? `SUPP_NONE
                    : (i == 1) ? `SUPP_ZERO_LEN : `SUPP_AMPL;
            end
            apb(1'b1, (op == 0) ? `OFF_CFG : (op == 1) ? `OFF_CFG_SET
                : `OFF_CFG_CLR, v);
            cfg_m = cfg_next(op, cfg_m, v);
            apb(1'b0, `OFF_CFG, 32'h0);
            check(rdat, cfg_m, "cfg word");
            check(chan_cfg.suppression, cfg_m[19:16], "supp");
            check(chan_cfg.dense_sample_packing, cfg_m[11], "pk");
            check(chan_cfg.trigger_on_under, cfg_m[6], "under");
            check(chan_cfg.sequential_access, cfg_m[4], "seq");
            check(chan_cfg.test_pattern, cfg_m[3], "pattern");
            check(chan_cfg.overlap_allowed, cfg_m[1], "overlap");
            check(acq_ctl.zero_length_encoding, cfg_m[19:16] == 4'h2,
                "zero len");
            check(acq_ctl.amplitude_full_suppression, cfg_m[19:16] == 4'h3,
                "ampl");
            apb(1'b0, (op == 1) ? `OFF_CFG_SET : `OFF_CFG_CLR, 32'h0);
            check(rdat, 32'h0, "alias read");
        end
        $display("config test finished");
        apb(1'b1, 16'h8200, 32'hffff_ffff);
        check(rerr, 1'b1, "unmapped wr");
        apb(1'b0, 16'h8200, 32'h0);
        check(rerr, 1'b1, "unmapped rd err");
        check(rdat, 32'h0, "unmapped rd");
        // sizing written only while stopped
        for (int k = 0; k < 2; k++) begin
            v = (k == 0) ? 32'h0 : ($random(seed) | 32'h1);
            apb(1'b1, `OFF_EVSIZE, v);
            apb(1'b0, `OFF_EVSIZE, 32'h0);
            check(rdat, v, "size read");
            check(event_location_count, v, "locations");
            check(custom_size_on, k[0], "size on");
        end
        for (int k = 0; k <= 10; k++) begin
            apb(1'b1, `OFF_BLK_DIV, k);
            apb(1'b0, `OFF_STAT, 32'h0);
            check(rdat[26:16], 32'h1 << k, "block count");
            check(block_div, k, "block div");
        end
        $display("sizing test finished");
        trigger_in <= 1'b1;
        sync_in <= $random(seed);
        apb(1'b1, `OFF_ACQ, 32'h4);
        seen = 1'b0;
        for (int k = 0; k < 10; k++) begin
            @(posedge pclk);
            seen = seen | (memory_reset === 1'b1);
            sync_in <= $random(seed);
        end
        check(seen, 1'b1, "memory reset");
        check({acq_ctl.running, acq_ctl.gate_open, acq_ctl.sync_enable,
            trigger_accept}, 4'hf, "mode 00");
        check(count_pulse, 1'b1, "count acc");
        pulse_events(5);
        apb(1'b1, `OFF_REL, 32'h2);
        apb(1'b0, `OFF_STAT, 32'h0);
        check(rdat[15:5], 32'h3, "released");
        apb(1'b1, `OFF_ACQ, 32'h0);
        pulse_events(2);
        apb(1'b0, `OFF_STAT, 32'h0);
        check(rdat[15:0], 32'h3 << 5, "kept");
        check({acq_ctl.running, trigger_accept, count_pulse}, 3'h0,
            "stopped");
        apb(1'b1, `OFF_REL, 32'h4);
        apb(1'b0, `OFF_STAT, 32'h0);
        check(rdat[31], 1'b1, "free error");
        apb(1'b1, `OFF_BLK_DIV, 32'h3);
        apb(1'b0, `OFF_STAT, 32'h0);
        check({rdat[31], rdat[15:5]}, 32'h0, "sw clear");
        $display("run test finished");
        sync_in <= 1'b0;
        apb(1'b1, `OFF_ACQ, 32'he);
        wait_run();
        repeat (3) @(posedge pclk);
        check({acq_ctl.gate_open, acq_ctl.sync_enable,
            trigger_accept}, 3'h0, "gate shut");
        check({acq_ctl.tally_all, count_pulse}, 2'h3, "all");
        sync_in <= 1'b1;
        repeat (3) @(posedge pclk);
        check({acq_ctl.gate_open, trigger_accept, count_pulse}, 3'h7,
            "gate open");
        apb(1'b0, `OFF_ACQ, 32'h0);
        check(rdat, 32'he, "acq read");
        apb(1'b1, `OFF_ACQ, 32'h0);
        sync_in <= 1'b0;
        apb(1'b1, `OFF_ACQ, 32'h5);
        repeat (6) @(posedge pclk);
        check(acq_ctl.running, 1'b0, "await sync");
        sync_in <= 1'b1;
        wait_run();
        repeat (2) @(posedge pclk);
        check({acq_ctl.running, acq_ctl.gate_open}, 2'h3,
            "sync start");
        apb(1'b1, `OFF_ACQ, 32'h0);
        apb(1'b1, `OFF_ACQ, 32'h7);
        wait_run();
        repeat (2) @(posedge pclk);
        check({acq_ctl.running, acq_ctl.sync_enable}, 2'h3,
            "multi");
        apb(1'b0, `OFF_ACQ, 32'h0);
        check(rdat, 32'h7, "acq read");
        $display("mode test finished");
        test_done();
    end
endmodule
